// >>> design/cbt_pkg.sv
// Package of constants and carrier types for the capacitive baseline tracker.
//
// Contract
// - Transfer rate select bit: 0 gives 512kHz, 1 gives 250kHz.
// - Auto-tune target select bit: 0 gives 1024 counts (default), 1 gives 512.
// - Slow baseline follows counts by IIR only while no proximity or touch event, except under the never policy.
// - Freeze timer starts on an event; on expiry the baseline is recalibrated.
// - Recalibration puts the baseline below the current count, clearing events.
// - Freeze field: 00 20 s, 01 40 s, 10 never, 11 always policy.
// - Never policy keeps the baseline filter running even during events.
// - Always policy: proximity freezes 40 s, touch freezes while touch persists.
// - The raw count IIR noise filter always runs and cannot be disabled.
// - Stream enable bit at bank 2 bit 7: 0 off, 1 on.
// - Stream protocol bit at bank 2 bit 5: 0 standalone, 1 I2C streaming.
// - With streaming on the device sends a record after every charge cycle; the code drops the record when its two-entry buffer is full.
// - I2C data rides on the proximity pin, I2C clock on the touch pin.
// - Control byte holds 7-bit address 0x44 then the read/write bit.
// - Auto-tune runs at start-up and when counts leave a preset range; code retunes only on count over 256 below target.
// - During auto-tune the stream flags it and no events are detected.
// - In normal operation retune only after a large sensitivity reduction.
// - Auto-tune adjusts coarse multiplier and fine compensation toward target.
// - Proximity when baseline minus count reaches threshold for 6 samples.
// - Touch when baseline minus count reaches threshold for 3 samples.
`default_nettype none
package cbt_pkg;
  localparam int CW = 16;
  localparam int BANK2_STREAM_EN_BIT = 7;
  localparam int BANK2_STREAM_I2C_BIT = 5;
  localparam logic [CW-1:0] TARGET_HI = 16'h0400;
  localparam logic [CW-1:0] TARGET_LO = 16'h0200;
  localparam int RATE_HI_KHZ = 512;
  localparam int RATE_LO_KHZ = 250;
  localparam int FREEZE_SHORT_S = 20;
  localparam int FREEZE_LONG_S = 40;
  localparam int CLK_MHZ = 125;
  localparam int PROX_RUN = 6;
  localparam int TOUCH_RUN = 3;
  localparam logic [6:0] DEV_ADDR = 7'h44;
  localparam int TUNE_WINDOW = 64;
  localparam int RECAL_MARGIN = 2;
  localparam logic [CW-1:0] BASE_RESET = 16'h0000;
  localparam logic [3:0] MULT_RESET = 4'h8;
  localparam logic [7:0] COMP_RESET = 8'h80;
  localparam int I2C_HALF_CYC = 8;

  typedef enum logic [1:0] {
    CBT_FZ_20S,
    CBT_FZ_40S,
    CBT_FZ_NEVER,
    CBT_FZ_ALWAYS
  } cbt_freeze_t;

  typedef struct packed {
    logic streaming_on;
    logic i2c_mode;
    logic rate_slow;
    logic target_low;
    cbt_freeze_t freeze;
    logic [3:0] prox_thr;
    logic [7:0] touch_frac;
  } cbt_cfg_t;

  typedef struct packed {
    logic [CW-1:0] count;
    logic [CW-1:0] baseline;
    logic prox;
    logic touch;
    logic tuning;
  } cbt_rec_t;
endpackage : cbt_pkg
`default_nettype wire

// >>> design/cbt_buf2.sv
// Two-entry valid/ready buffer used in the streamed record path.
`timescale 1ns/1ns
`default_nettype none
module cbt_buf2 #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic wp;
  logic rp;
  logic [1:0] fill;
  logic push;
  logic pop;

  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wp <= 1'b0;
      rp <= 1'b0;
      fill <= 2'h0;
    end else begin
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : cbt_buf2
`default_nettype wire

// >>> design/cbt_core.sv
// Baseline tracking, event detection, auto-tune and I2C streaming core.
`timescale 1ns/1ns
`default_nettype none
module cbt_core #(
  parameter longint FREEZE_SHORT_CYC = longint'(cbt_pkg::FREEZE_SHORT_S) * cbt_pkg::CLK_MHZ * 1000000,
  parameter longint FREEZE_LONG_CYC = longint'(cbt_pkg::FREEZE_LONG_S) * cbt_pkg::CLK_MHZ * 1000000,
  parameter int RAW_SHIFT = 2,
  parameter int BASE_SHIFT = 6
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Configuration.
  input wire cbt_pkg::cbt_cfg_t cfg,
  // Sampled charge cycle result from the front end.
  input wire logic sample_valid,
  input wire logic [cbt_pkg::CW-1:0] raw_count,
  // Front end tuning controls.
  output logic rate_slow,
  output logic [3:0] tune_mult,
  output logic [7:0] tune_comp,
  // Detection status.
  output logic prox_event,
  output logic touch_event,
  output logic tuning,
  output logic [cbt_pkg::CW-1:0] baseline,
  output logic [cbt_pkg::CW-1:0] filt_count,
  // Proximity pin, doubling as I2C data.
  input wire logic pout_in,
  output logic pout_out,
  output logic pout_oe,
  // Touch pin, doubling as I2C clock.
  input wire logic tout_in,
  output logic tout_out,
  output logic tout_oe,
  // Streaming status.
  output logic stream_drop,
  output logic stream_nack
);
  localparam int CW = cbt_pkg::CW;
  localparam int RECW = $bits(cbt_pkg::cbt_rec_t);
  localparam int NBYTE = 5;

  logic streaming;
  logic [CW-1:0] target;
  logic [CW-1:0] diff;
  logic [CW-1:0] touch_thr;
  logic [2:0] prox_run;
  logic [1:0] touch_run;
  // Forty seconds of the system clock does not fit in 32 bits.
  logic [32:0] frz_cnt;
  logic frz_active;
  logic frz_expired;
  logic filter_run;
  logic recal;
  logic [CW+1:0] raw_acc;
  logic [CW+5:0] base_acc;
  logic [6:0] tune_cnt;
  logic tune_init;

  assign streaming = cfg.streaming_on && cfg.i2c_mode;
  assign rate_slow = cfg.rate_slow;
  assign target = cfg.target_low ? cbt_pkg::TARGET_LO : cbt_pkg::TARGET_HI;

  // The noise filter has no bypass, so every detector sees filtered counts.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      raw_acc <= '0;
      filt_count <= '0;
    end else if (sample_valid) begin
      raw_acc <= raw_acc - {2'h0, filt_count} + {2'h0, raw_count};
      filt_count <= CW'((raw_acc - {2'h0, filt_count} + {2'h0, raw_count}) >> RAW_SHIFT);
    end
  end

  assign diff = (baseline > filt_count) ? baseline - filt_count : '0;
  assign touch_thr = CW'(({8'h00, baseline} * {8'h00, cfg.touch_frac}) >> 8);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || tuning || recal) begin
      prox_run <= '0;
      touch_run <= '0;
    end else if (sample_valid) begin
      if (diff >= {12'h000, cfg.prox_thr} && diff != '0) begin
        prox_run <= (prox_run == 3'(cbt_pkg::PROX_RUN)) ? prox_run : prox_run + 3'h1;
      end else begin
        prox_run <= '0;
      end
      if (diff >= touch_thr && diff != '0) begin
        touch_run <= (touch_run == 2'(cbt_pkg::TOUCH_RUN)) ? touch_run : touch_run + 2'h1;
      end else begin
        touch_run <= '0;
      end
    end
  end
  assign prox_event = (prox_run == 3'(cbt_pkg::PROX_RUN));
  assign touch_event = (touch_run == 2'(cbt_pkg::TOUCH_RUN));

  // Freeze timer: runs from the first event cycle and restarts when events clear.
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !(prox_event || touch_event) || recal) begin
      frz_cnt <= '0;
    end else if (!frz_expired) begin
      frz_cnt <= frz_cnt + 33'h1;
    end
  end
  assign frz_active = prox_event || touch_event;

  always_comb begin
    unique case (cfg.freeze)
      cbt_pkg::CBT_FZ_20S: frz_expired = frz_cnt >= 33'(FREEZE_SHORT_CYC);
      cbt_pkg::CBT_FZ_40S: frz_expired = frz_cnt >= 33'(FREEZE_LONG_CYC);
      cbt_pkg::CBT_FZ_NEVER: frz_expired = 1'b0;
      cbt_pkg::CBT_FZ_ALWAYS: frz_expired = !touch_event && frz_cnt >= 33'(FREEZE_LONG_CYC);
    endcase
  end
  assign recal = frz_active && frz_expired && cfg.freeze != cbt_pkg::CBT_FZ_NEVER;
  assign filter_run = !frz_active || cfg.freeze == cbt_pkg::CBT_FZ_NEVER;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || tuning) begin
      base_acc <= '0;
      baseline <= cbt_pkg::BASE_RESET;
    end else if (recal) begin
      baseline <= filt_count - CW'(cbt_pkg::RECAL_MARGIN);
      base_acc <= {filt_count - CW'(cbt_pkg::RECAL_MARGIN), 6'h00};
    end else if (tune_init) begin
      baseline <= filt_count;
      base_acc <= {filt_count, 6'h00};
    end else if (sample_valid && filter_run) begin
      base_acc <= base_acc - {6'h00, baseline} + {6'h00, filt_count};
      baseline <= CW'((base_acc - {6'h00, baseline} + {6'h00, filt_count}) >> BASE_SHIFT);
    end
  end

  // Auto-tune: one fine step per sample, a coarse step when fine runs out, until count nears the target.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tuning <= 1'b1;
      tune_mult <= cbt_pkg::MULT_RESET;
      tune_comp <= cbt_pkg::COMP_RESET;
      tune_init <= 1'b0;
    end else begin
      tune_init <= 1'b0;
      if (tuning && sample_valid) begin
        if (filt_count + 16'(cbt_pkg::TUNE_WINDOW) < target) begin
          if (tune_comp == 8'h00) begin
            tune_mult <= tune_mult - 4'h1;
            tune_comp <= cbt_pkg::COMP_RESET;
          end else begin
            tune_comp <= tune_comp - 8'h01;
          end
        end else if (filt_count > target + 16'(cbt_pkg::TUNE_WINDOW)) begin
          if (tune_comp == 8'hFF) begin
            tune_mult <= tune_mult + 4'h1;
            tune_comp <= cbt_pkg::COMP_RESET;
          end else begin
            tune_comp <= tune_comp + 8'h01;
          end
        end else begin
          tuning <= 1'b0;
          tune_init <= 1'b1;
        end
      end else if (!tuning && sample_valid && !frz_active
                   && filt_count + 16'(4 * cbt_pkg::TUNE_WINDOW) < target) begin
        tuning <= 1'b1;
      end
    end
  end

  // Record buffer between the sample path and the I2C sender.
  cbt_pkg::cbt_rec_t rec_in;
  logic [RECW-1:0] rec_out;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;

  assign rec_in = '{count: filt_count, baseline: baseline, prox: prox_event,
                    touch: touch_event, tuning: tuning};
  logic stream_drop_c;
  assign stream_drop_c = streaming && sample_valid && !buf_in_ready;

  cbt_buf2 #(.W(RECW)) u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(streaming && sample_valid),
    .in_ready(buf_in_ready),
    .in_data(rec_in),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(rec_out)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stream_drop <= 1'b0;
    end else begin
      stream_drop <= stream_drop_c;
    end
  end

  // I2C master: start, address byte, five record bytes, stop.
  typedef enum logic [2:0] {
    CBT_IDLE, CBT_START, CBT_BIT, CBT_ACK, CBT_STOP
  } cbt_i2c_t;
  cbt_i2c_t st;
  logic [3:0] half;
  logic phase;
  logic [2:0] bitn;
  logic [2:0] byten;
  logic [8*(NBYTE+1)-1:0] shreg;
  logic sda_s1;
  logic sda_s2;
  logic scl_s1;
  logic scl_s2;
  logic tick;

  always_ff @(posedge ref_clk) begin
    sda_s1 <= pout_in;
    sda_s2 <= sda_s1;
    scl_s1 <= tout_in;
    scl_s2 <= scl_s1;
  end

  assign tick = (half == 4'(cbt_pkg::I2C_HALF_CYC - 1));
  assign buf_out_ready = (st == CBT_IDLE) && streaming;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || st == CBT_IDLE) begin
      half <= '0;
    end else begin
      half <= tick ? 4'h0 : half + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= CBT_IDLE;
      phase <= 1'b0;
      bitn <= '0;
      byten <= '0;
      shreg <= '0;
      stream_nack <= 1'b0;
    end else begin
      unique case (st)
        CBT_IDLE: begin
          if (buf_out_valid && streaming) begin
            shreg <= {cbt_pkg::DEV_ADDR, 1'b0, rec_out, 5'h00};
            st <= CBT_START;
          end
        end
        CBT_START: begin
          if (tick) begin
            st <= CBT_BIT;
            phase <= 1'b0;
            bitn <= '0;
            byten <= '0;
          end
        end
        CBT_BIT: begin
          if (tick) begin
            phase <= ~phase;
            if (phase) begin
              shreg <= {shreg[8*(NBYTE+1)-2:0], 1'b0};
              bitn <= bitn + 3'h1;
              if (bitn == 3'h7) begin
                st <= CBT_ACK;
              end
            end
          end
        end
        CBT_ACK: begin
          if (tick) begin
            phase <= ~phase;
            if (phase) begin
              stream_nack <= sda_s2 && scl_s2;
              byten <= byten + 3'h1;
              st <= (byten == 3'(NBYTE) || sda_s2) ? CBT_STOP : CBT_BIT;
            end
          end
        end
        CBT_STOP: begin
          // Clock low first, so data can fall without forming a start condition.
          if (tick) begin
            phase <= ~phase;
            if (phase) begin
              st <= CBT_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pins: normal outputs unless I2C streaming is on.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pout_out <= 1'b0;
      pout_oe <= 1'b1;
      tout_out <= 1'b0;
      tout_oe <= 1'b1;
    end else if (!streaming) begin
      pout_out <= prox_event;
      pout_oe <= 1'b1;
      tout_out <= touch_event;
      tout_oe <= 1'b1;
    end else begin
      // Open drain: drive low only, release for high.
      pout_out <= 1'b0;
      tout_out <= 1'b0;
      unique case (st)
        CBT_IDLE: begin
          pout_oe <= 1'b0;
          tout_oe <= 1'b0;
        end
        CBT_START: begin
          pout_oe <= 1'b1;
          tout_oe <= tick;
        end
        CBT_BIT: begin
          pout_oe <= ~shreg[8*(NBYTE+1)-1];
          tout_oe <= ~phase;
        end
        CBT_ACK: begin
          pout_oe <= 1'b0;
          tout_oe <= ~phase;
        end
        CBT_STOP: begin
          pout_oe <= 1'b1;
          tout_oe <= ~phase;
        end
      endcase
    end
  end
endmodule : cbt_core
`default_nettype wire

// >>> bench/cbt_props.sv
// Concurrent checks on the ports of the baseline tracker core.
`timescale 1ns/1ns
`default_nettype none
module cbt_props #(
  parameter longint FREEZE_SHORT_CYC = 200,
  parameter longint FREEZE_LONG_CYC = 400
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Watched ports.
  input wire cbt_pkg::cbt_cfg_t cfg,
  input wire logic sample_valid,
  input wire logic rate_slow,
  input wire logic prox_event,
  input wire logic touch_event,
  input wire logic tuning,
  input wire logic [cbt_pkg::CW-1:0] baseline,
  input wire logic [cbt_pkg::CW-1:0] filt_count,
  input wire logic pout_out,
  input wire logic pout_oe,
  input wire logic tout_out,
  input wire logic tout_oe,
  input wire logic stream_drop
);
  wire logic sm = cfg.streaming_on & cfg.i2c_mode;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  rate_follow_a: assert property (rate_slow == cfg.rate_slow)
    else $error("rate select not followed");
  reset_state_a: assert property ($past(sys_rst) |-> tuning && !prox_event
    && !touch_event && baseline == cbt_pkg::BASE_RESET) else $error("bad state after reset");
  tune_quiet_a: assert property (tuning && $past(tuning) |-> !prox_event && !touch_event)
    else $error("event while tuning");
  filt_holds_a: assert property (!$past(sample_valid) && !$past(sample_valid, 2)
    |-> $stable(filt_count)) else $error("filtered count moved without a sample");
  normal_pins_a: assert property (!sm && !$past(sm) && $stable(prox_event)
    && $stable(touch_event) |-> pout_oe && tout_oe && pout_out == prox_event
    && tout_out == touch_event) else $error("pins do not show events");
  drain_only_a: assert property (sm && $past(sm) |-> !pout_out && !tout_out)
    else $error("link pin driven high");
  scl_low_a: assert property (sm && $rose(tout_oe) |-> tout_oe [*8])
    else $error("clock low phase too short");
  scl_high_a: assert property (sm && $past(sm) && $fell(tout_oe) |-> !tout_oe [*8])
    else $error("clock high phase too short");
  drop_idle_a: assert property (!sm && !$past(sm) |-> !stream_drop)
    else $error("drop without streaming");
endmodule : cbt_props
bind cbt_core cbt_props #(.FREEZE_SHORT_CYC(FREEZE_SHORT_CYC), .FREEZE_LONG_CYC(FREEZE_LONG_CYC))
  i_cbt_props (.ref_clk, .sys_rst, .cfg, .sample_valid, .rate_slow, .prox_event, .touch_event,
  .tuning, .baseline, .filt_count, .pout_out, .pout_oe, .tout_out, .tout_oe, .stream_drop);
`default_nettype wire

// >>> bench/cbt_mcu.sv
// Receiving controller model on the streamed two-wire link.
`timescale 1ns/1ns
`default_nettype none
module cbt_mcu (
  // Clock.
  input wire logic ref_clk,
  // Resolved link wires.
  input wire logic sda,
  input wire logic scl,
  // Bench controls.
  input wire logic listen,
  input wire logic refuse,
  // Data line pull-down.
  output logic sda_oe
);
  logic sda_q = 1'b1;
  logic scl_q = 1'b1;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] bytes[$];
  int nbit = -1;
  int frames = 0;
  wire logic idle = nbit < 0;
  initial sda_oe = 1'b0;
  always @(posedge ref_clk) begin
    if (!listen) begin
      nbit = -1;
      sda_oe <= 1'b0;
    end else if (scl && scl_q && sda_q && !sda) begin
      nbit = 0;
      first = 1'b1;
      frames++;
    end else if (scl && scl_q && !sda_q && sda) begin
      nbit = -1;
    end else if (nbit >= 0 && scl && !scl_q) begin
      if (nbit < 8) sh = {sh[6:0], sda};
      nbit++;
    end else if (nbit == 8 && !scl && scl_q) begin
      bytes.push_back(sh);
      // Only a write to the sensor's own address is answered.
      sda_oe <= !refuse && (!first || sh == {cbt_pkg::DEV_ADDR, 1'b0});
      first = 1'b0;
    end else if (nbit == 9 && !scl && scl_q) begin
      sda_oe <= 1'b0;
      nbit = 0;
    end
    sda_q = sda;
    scl_q = scl;
  end
endmodule : cbt_mcu
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the baseline tracker core.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int SHORT = 200;
  localparam int LONG = 400;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_valid = 1'b0;
  logic refuse = 1'b0;
  logic [15:0] raw_count = 16'h0400;
  logic [15:0] lvl;
  logic [15:0] held;
  cbt_pkg::cbt_cfg_t cfg = '0;
  wire logic rate_slow, prox_event, touch_event, tuning, pout_out, pout_oe, tout_out, tout_oe;
  wire logic mcu_oe, stream_drop, stream_nack;
  wire logic [3:0] tune_mult;
  wire logic [7:0] tune_comp;
  wire logic [15:0] baseline, filt_count;
  // Both link wires have pull-ups, so a released line reads high.
  wire logic sda = (pout_oe ? pout_out : 1'b1) & !mcu_oe;
  wire logic scl = tout_oe ? tout_out : 1'b1;
  wire logic listen = cfg.streaming_on & cfg.i2c_mode;
  int n_errors = 0;
  int n_compared = 0;
  int n_drop = 0;
  int k;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (stream_drop === 1'b1) n_drop <= n_drop + 1;
  cbt_core #(.FREEZE_SHORT_CYC(SHORT), .FREEZE_LONG_CYC(LONG)) i_cbt_core (.ref_clk, .sys_rst,
    .cfg, .sample_valid, .raw_count, .rate_slow, .tune_mult, .tune_comp, .prox_event,
    .touch_event, .tuning, .baseline, .filt_count, .pout_in(sda), .pout_out, .pout_oe,
    .tout_in(scl), .tout_out, .tout_oe, .stream_drop, .stream_nack);
  cbt_mcu i_mcu (.ref_clk, .sda, .scl, .listen, .refuse, .sda_oe(mcu_oe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Sends n charge cycle results of one value, one every four cycles.
  task automatic feed(input logic [15:0] value, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      raw_count = value;
      sample_valid = 1'b1;
      @(negedge ref_clk);
      sample_valid = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask : feed
  task automatic tune_until(input logic [15:0] value, input logic want);
    for (k = 0; k < 500 && tuning !== want; k++) feed(value, 1);
    check(tuning, want);
    if (tuning !== want) results();
  endtask : tune_until
  task automatic wait_frames(input int n);
    for (k = 0; k < 30000 && !(i_mcu.frames == n && i_mcu.idle); k++) @(negedge ref_clk);
    check(16'(k < 30000), 16'h1);
    if (k == 30000) results();
  endtask : wait_frames
  initial begin
    cfg.prox_thr = 4'h4;
    cfg.touch_frac = 8'h08;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    cfg.rate_slow = 1'b1;
    #1 check(rate_slow, 16'h1);
    cfg.rate_slow = 1'b0;
    tune_until(16'h0400, 1'b0);
    check(16'(tune_comp != cbt_pkg::COMP_RESET), 16'h1);
    feed(16'h0400, 500);
    cfg.freeze = cbt_pkg::CBT_FZ_NEVER;
    held = baseline;
    feed(held - 16'd80, 12);
    check(prox_event, 1'b1);
    check(16'(baseline < held), 16'h1);
    feed(baseline, 20);
    for (int p = 0; p < 2; p++) begin
      cfg.freeze = p ? cbt_pkg::CBT_FZ_40S : cbt_pkg::CBT_FZ_20S;
      lvl = baseline - 16'd50;
      feed(lvl, 2);
      check(touch_event, 1'b0);
      feed(lvl, 3);
      check(prox_event, 1'b0);
      feed(lvl, 5);
      check({prox_event, touch_event}, 2'b11);
      held = baseline;
      feed(lvl, 5);
      check(baseline, held);
      // The event is still held shortly before the selected limit runs out.
      feed(lvl, (p ? LONG : SHORT) / 4 - 20);
      check(prox_event, 1'b1);
      feed(lvl, 40);
      check(prox_event, 1'b0);
      check(16'(baseline < filt_count), 16'h1);
    end
    cfg.freeze = cbt_pkg::CBT_FZ_ALWAYS;
    lvl = baseline - 16'd50;
    feed(lvl, 12);
    held = baseline;
    feed(lvl, 120);
    check(touch_event, 1'b1);
    check(baseline, held);
    feed(held, 20);
    cfg.freeze = cbt_pkg::CBT_FZ_NEVER;
    tune_until(16'h02BC, 1'b1);
    check(prox_event | touch_event, 1'b0);
    cfg.target_low = 1'b1;
    tune_until(16'h0200, 1'b0);
    cfg.streaming_on = 1'b1;
    cfg.i2c_mode = 1'b1;
    feed(16'h0200, 1);
    wait_frames(1);
    check(16'(i_mcu.bytes.size()), 16'd6);
    check(i_mcu.bytes[0], 8'h88);
    check(i_mcu.bytes[1], 8'h02);
    check(i_mcu.bytes[5] & 8'h3F, 8'h00);
    feed(16'h0200, 4);
    wait_frames(4);
    check(16'(n_drop), 16'd1);
    refuse = 1'b1;
    feed(16'h0200, 1);
    wait_frames(5);
    check(16'(i_mcu.bytes.size()), 16'd25);
    check(stream_nack, 1'b1);
    refuse = 1'b0;
    for (int m = 0; m < 2; m++) begin
      cfg.streaming_on = m[0];
      cfg.i2c_mode = !m[0];
      feed(16'h0200, 1);
      k = 0;
      repeat (900) @(negedge ref_clk) k += 32'(!(pout_oe === 1'b1 && tout_oe === 1'b1));
      check(16'(k), 16'd0);
    end
    results();
  end
endmodule : tb
`default_nettype wire
